// File: include/szs_pkg.sv
// Constants, state codes and carrier types of the standstill and stop sequencer.
// Speeds and levels are signed 0.01 % units, times are 0.1 s units.
`default_nettype none

package szs_pkg;

	localparam int          DW             = 16;
	localparam int          AW             = 4;

	// Register indexes
	localparam logic [3:0]  OFS_ZERO_LVL   = 4'h0;
	localparam logic [3:0]  OFS_NSTOP_TIME = 4'h1;
	localparam logic [3:0]  OFS_NSTOP_LIM  = 4'h2;
	localparam logic [3:0]  OFS_HOLD_DLY   = 4'h3;
	localparam logic [3:0]  OFS_QUENCH     = 4'h4;
	localparam logic [3:0]  OFS_FAST_TIME  = 4'h5;
	localparam logic [3:0]  OFS_FAST_LIM   = 4'h6;
	localparam logic [3:0]  OFS_FAST_ILIM  = 4'h7;
	localparam logic [3:0]  OFS_STOP_ZERO  = 4'h8;
	localparam logic [3:0]  OFS_CTRL       = 4'h9;
	localparam logic [3:0]  OFS_STATUS     = 4'hA;
	localparam logic [3:0]  OFS_DEMAND     = 4'hB;

	// Reset values
	localparam logic [15:0] RST_ZERO_LVL   = 16'h00C8;
	localparam logic [15:0] RST_NSTOP_TIME = 16'h0064;
	localparam logic [15:0] RST_NSTOP_LIM  = 16'h0258;
	localparam logic [15:0] RST_HOLD_DLY   = 16'h000A;
	localparam logic [15:0] RST_QUENCH     = 16'h0000;
	localparam logic [15:0] RST_FAST_TIME  = 16'h0001;
	localparam logic [15:0] RST_FAST_LIM   = 16'h0258;
	localparam logic [15:0] RST_FAST_ILIM  = 16'h2710;
	localparam logic [15:0] RST_STOP_ZERO  = 16'h00C8;
	localparam logic [15:0] RST_CTRL       = 16'h0002;

	// Control register bits
	localparam int          CTRL_STILL_EN  = 0;
	localparam int          CTRL_REGEN     = 1;

	// Levels
	localparam logic [15:0] HYST_BAND      = 16'h0032;
	localparam logic [15:0] EARLY_OFF_LVL  = 16'h0019;
	localparam logic [15:0] FULL_SPEED     = 16'h2710;
	localparam logic [15:0] ILIM_NONE      = 16'h4E20;

	// Timing
	localparam int          CLK_NS         = 40;
	localparam int          TICK_NS        = 100000000;
	localparam int          TICK_CYC_DEF   = TICK_NS / CLK_NS;

	typedef enum logic [5:0] {
		ST_OFF   = 6'h01,
		ST_RUN   = 6'h02,
		ST_NSTOP = 6'h04,
		ST_HOLD  = 6'h08,
		ST_PSTOP = 6'h10,
		ST_LOCK  = 6'h20
	} szs_state_t;

	typedef struct packed {
		logic [15:0] zero_lvl;
		logic [15:0] nstop_time;
		logic [15:0] nstop_lim;
		logic [15:0] hold_dly;
		logic [15:0] quench;
		logic [15:0] fast_time;
		logic [15:0] fast_lim;
		logic [15:0] fast_ilim;
		logic [15:0] stop_zero;
		logic [15:0] ctrl;
	} szs_cfg_t;

	typedef struct packed {
		logic speed_near_zero_flag;
		logic setpoint_near_zero_flag;
		logic motor_stopped_flag;
	} szs_flags_t;

endpackage : szs_pkg

`default_nettype wire

// File: rtl/szs_tick.sv
// Tick of 0.1 s for the stop timers and the hold delay.
// Assumes clr is a one-cycle pulse that restarts the period.
`default_nettype none

module szs_tick #(
	parameter int TICK_CYC = 2500000
) (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	input  wire logic clr,
	output var  logic tick
);
	import szs_pkg::*;

	typedef struct packed {
		logic [31:0] cnt;
		logic        tick;
	} szs_tick_t;

	szs_tick_t s_r;
	szs_tick_t s_nxt;

	always_comb begin
		s_nxt      = s_r;
		s_nxt.tick = 1'b0;
		if (clr) begin
			s_nxt.cnt = 32'h0000_0000;
		end else if (s_r.cnt >= 32'(TICK_CYC - 1)) begin
			s_nxt.cnt  = 32'h0000_0000;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick = s_r.tick;

endmodule : szs_tick

`default_nettype wire

// File: rtl/szs_hyst.sv
// Near-zero comparator with a hysteresis band above the level.
// Assumes value and level come from logic on sys_clk.
`default_nettype none

module szs_hyst (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic [15:0] mag,
	input  wire logic [15:0] level,
	output var  logic        flag
);
	import szs_pkg::*;

	typedef struct packed {
		logic flag;
	} szs_hyst_t;

	szs_hyst_t   s_r;
	szs_hyst_t   s_nxt;
	logic [16:0] upper;

	assign upper = {1'b0, level} + {1'b0, HYST_BAND};

	always_comb begin
		s_nxt = s_r;
		if (!s_r.flag && mag < level) begin
			s_nxt.flag = 1'b1;
		end else if (s_r.flag && {1'b0, mag} >= upper) begin
			s_nxt.flag = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign flag = s_r.flag;

	AST_HYST_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst)
		flag && ({1'b0, mag} < upper) |=> flag)
		else $error("near-zero flag dropped inside the band");
	AST_HYST_SET: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!sys_rst && (mag < level) |=> flag)
		else $error("near-zero flag not set below level");

endmodule : szs_hyst

`default_nettype wire

// File: rtl/szs_seq.sv
// Standstill detection and stop sequencing of a DC drive.
// Assumes terminal pins are asynchronous, high means released/run.
//
// How it works
// - Speed near-zero below zero level
// - Setpoint near-zero below zero level
// - Half percent hysteresis on both tests
// - Stopped when both near-zero flags true
// - Stopped and enabled in run quench loops, keep contactor
// - Quench lasts until stopped flag clears
// - Not-stopped is inverse of stopped
// - Zero relay follows speed near-zero
// - Run removed ramps demand over stop time
// - Non-regen drive coasts, regen ramps
// - Normal stop end drops contactor, disables
// - Normal stop limit timer forces stop
// - Hold contactor for delay at zero
// - Early disable if level>0.25% and decay
// - Enable low cancels contactor delay
// - Halt low starts fast ramp
// - Fast stop at zero drops contactor
// - Fast stop limit timer forces stop
// - Fast stop applies its current limit
`default_nettype none

module szs_seq #(
	parameter int TICK_CYC = szs_pkg::TICK_CYC_DEF
) (
	input  wire logic               sys_clk,
	input  wire logic               sys_rst,
	input  wire logic [3:0]         reg_addr,
	input  wire logic [15:0]        reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output var  logic [15:0]        reg_rdata,
	input  wire logic               run_input,
	input  wire logic               fast_halt_input,
	input  wire logic               enable_input,
	input  wire logic               coast_input,
	input  wire logic signed [15:0] speed_fb,
	input  wire logic signed [15:0] speed_setpoint,
	output var  szs_pkg::szs_flags_t flags,
	output var  logic               zero_relay,
	output var  logic               not_stopped,
	output var  logic               loops_enable,
	output var  logic               contactor_on,
	output var  logic               drive_enable,
	output var  logic               run_led,
	output var  logic signed [15:0] speed_demand,
	output var  logic [15:0]        current_limit
);
	import szs_pkg::*;

	localparam int STEP_CYC = TICK_CYC / 10000;

	typedef struct packed {
		szs_cfg_t           cfg;
		logic [3:0]         sy1;
		logic [3:0]         sy2;
		szs_state_t         st;
		logic               fresh;
		logic [15:0]        tmr;
		logic [31:0]        scnt;
		logic signed [15:0] dem;
		logic [15:0]        rdata;
	} szs_main_t;

	szs_main_t   s_r;
	szs_main_t   s_nxt;
	logic        tick;
	logic        speed_nz;
	logic        setpt_nz;
	logic        stopped;
	logic [15:0] fb_mag;
	logic [15:0] sp_mag;
	logic        run_ok;
	logic        halt_ok;
	logic        en_ok;
	logic        coast_ok;
	logic        at_stop_zero;
	logic        early_off;
	logic        quench_now;
	logic [31:0] step_per;
	logic        step;

	function automatic logic [15:0] mag16(input logic signed [15:0] v);
		mag16 = v[15] ? 16'(-v) : 16'(v);
	endfunction : mag16

	assign fb_mag = mag16(speed_fb);
	assign sp_mag = mag16(speed_setpoint);

	szs_hyst u_speed_hyst (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.mag     (fb_mag),
		.level   (s_r.cfg.zero_lvl),
		.flag    (speed_nz)
	);

	szs_hyst u_setpt_hyst (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.mag     (sp_mag),
		.level   (s_r.cfg.zero_lvl),
		.flag    (setpt_nz)
	);

	szs_tick #(
		.TICK_CYC (TICK_CYC)
	) u_tick (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.clr     (s_r.fresh),
		.tick    (tick)
	);

	assign stopped  = speed_nz && setpt_nz;
	assign run_ok   = s_r.sy2[0];
	assign halt_ok  = s_r.sy2[1];
	assign en_ok    = s_r.sy2[2];
	assign coast_ok = s_r.sy2[3];

	assign at_stop_zero = fb_mag < s_r.cfg.stop_zero;
	assign early_off    = (s_r.cfg.stop_zero > EARLY_OFF_LVL) && (s_r.cfg.quench != 16'h0000);
	assign quench_now   = (s_r.st == ST_RUN) && stopped && s_r.cfg.ctrl[CTRL_STILL_EN];

	// Ramp step period for one 0.01 % step
	always_comb begin
		step_per = 32'(STEP_CYC) * 32'((s_r.st == ST_PSTOP) ? s_r.cfg.fast_time : s_r.cfg.nstop_time);
		step     = (s_r.scnt + 32'h0000_0001) >= step_per;
	end

	always_comb begin
		s_nxt       = s_r;
		s_nxt.sy1   = {coast_input, enable_input, fast_halt_input, run_input};
		s_nxt.sy2   = s_r.sy1;
		s_nxt.fresh = 1'b0;
		s_nxt.rdata = 16'h0000;

		if (reg_wr) begin
			unique case (reg_addr)
				OFS_ZERO_LVL:   s_nxt.cfg.zero_lvl   = reg_wdata;
				OFS_NSTOP_TIME: s_nxt.cfg.nstop_time = reg_wdata;
				OFS_NSTOP_LIM:  s_nxt.cfg.nstop_lim  = reg_wdata;
				OFS_HOLD_DLY:   s_nxt.cfg.hold_dly   = reg_wdata;
				OFS_QUENCH:     s_nxt.cfg.quench     = reg_wdata;
				OFS_FAST_TIME:  s_nxt.cfg.fast_time  = reg_wdata;
				OFS_FAST_LIM:   s_nxt.cfg.fast_lim   = reg_wdata;
				OFS_FAST_ILIM:  s_nxt.cfg.fast_ilim  = reg_wdata;
				OFS_STOP_ZERO:  s_nxt.cfg.stop_zero  = reg_wdata;
				OFS_CTRL:       s_nxt.cfg.ctrl       = {14'h0000, reg_wdata[1:0]};
				default:        ;
			endcase
		end

		if (reg_rd) begin
			unique case (reg_addr)
				OFS_ZERO_LVL:   s_nxt.rdata = s_r.cfg.zero_lvl;
				OFS_NSTOP_TIME: s_nxt.rdata = s_r.cfg.nstop_time;
				OFS_NSTOP_LIM:  s_nxt.rdata = s_r.cfg.nstop_lim;
				OFS_HOLD_DLY:   s_nxt.rdata = s_r.cfg.hold_dly;
				OFS_QUENCH:     s_nxt.rdata = s_r.cfg.quench;
				OFS_FAST_TIME:  s_nxt.rdata = s_r.cfg.fast_time;
				OFS_FAST_LIM:   s_nxt.rdata = s_r.cfg.fast_lim;
				OFS_FAST_ILIM:  s_nxt.rdata = s_r.cfg.fast_ilim;
				OFS_STOP_ZERO:  s_nxt.rdata = s_r.cfg.stop_zero;
				OFS_CTRL:       s_nxt.rdata = s_r.cfg.ctrl;
				OFS_STATUS:     s_nxt.rdata = {2'h0, s_r.st, quench_now, stopped, setpt_nz, speed_nz,
								contactor_on, drive_enable, loops_enable, 1'b0};
				OFS_DEMAND:     s_nxt.rdata = s_r.dem;
				default:        s_nxt.rdata = 16'h0000;
			endcase
		end

		// Elapsed 0.1 s ticks in the current state
		if (tick && !s_r.fresh && s_r.tmr != 16'hFFFF) begin
			s_nxt.tmr = s_r.tmr + 16'h0001;
		end

		// Ramp demand toward zero, one 0.01 % step per period
		s_nxt.scnt = step ? 32'h0000_0000 : s_r.scnt + 32'h0000_0001;

		unique case (s_r.st)
			ST_OFF: begin
				s_nxt.dem = 16'sh0000;
				if (run_ok) begin
					s_nxt.st = (halt_ok && coast_ok) ? ST_RUN : ST_LOCK;
				end
			end
			ST_RUN: begin
				s_nxt.dem = speed_setpoint;
				if (!halt_ok) begin
					s_nxt.st = ST_PSTOP;
				end else if (!run_ok) begin
					s_nxt.st = ST_NSTOP;
				end
			end
			ST_NSTOP: begin
				if (!s_r.cfg.ctrl[CTRL_REGEN]) begin
					s_nxt.dem = 16'sh0000;
				end else if (step && s_r.dem != 16'sh0000) begin
					s_nxt.dem = s_r.dem[15] ? s_r.dem + 16'sh0001 : s_r.dem - 16'sh0001;
				end
				if (!halt_ok) begin
					s_nxt.st = ST_PSTOP;
				end else if (run_ok) begin
					s_nxt.st = ST_RUN;
				end else if (at_stop_zero) begin
					s_nxt.st = ST_HOLD;
				end else if (s_r.tmr >= s_r.cfg.nstop_lim) begin
					s_nxt.st = ST_LOCK;
				end
			end
			ST_HOLD: begin
				s_nxt.dem = 16'sh0000;
				if (!halt_ok) begin
					s_nxt.st = ST_PSTOP;
				end else if (!en_ok) begin
					s_nxt.st = ST_LOCK;
				end else if (s_r.tmr >= s_r.cfg.hold_dly) begin
					s_nxt.st = ST_LOCK;
				end
			end
			ST_PSTOP: begin
				if (step && s_r.dem != 16'sh0000) begin
					s_nxt.dem = s_r.dem[15] ? s_r.dem + 16'sh0001 : s_r.dem - 16'sh0001;
				end
				if (at_stop_zero) begin
					s_nxt.st = ST_LOCK;
				end else if (s_r.tmr >= s_r.cfg.fast_lim) begin
					s_nxt.st = ST_LOCK;
				end
			end
			ST_LOCK: begin
				s_nxt.dem = 16'sh0000;
				if (!run_ok && halt_ok) begin
					s_nxt.st = ST_OFF;
				end
			end
			default: begin
				s_nxt.st = ST_LOCK;
			end
		endcase

		// Coast drops everything at once
		if (!coast_ok && s_r.st != ST_OFF && s_r.st != ST_LOCK) begin
			s_nxt.st = ST_LOCK;
		end

		if (s_nxt.st != s_r.st) begin
			s_nxt.fresh = 1'b1;
			s_nxt.tmr   = 16'h0000;
			s_nxt.scnt  = 32'h0000_0000;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_r                <= '0;
			s_r.st             <= ST_OFF;
			s_r.cfg.zero_lvl   <= RST_ZERO_LVL;
			s_r.cfg.nstop_time <= RST_NSTOP_TIME;
			s_r.cfg.nstop_lim  <= RST_NSTOP_LIM;
			s_r.cfg.hold_dly   <= RST_HOLD_DLY;
			s_r.cfg.quench     <= RST_QUENCH;
			s_r.cfg.fast_time  <= RST_FAST_TIME;
			s_r.cfg.fast_lim   <= RST_FAST_LIM;
			s_r.cfg.fast_ilim  <= RST_FAST_ILIM;
			s_r.cfg.stop_zero  <= RST_STOP_ZERO;
			s_r.cfg.ctrl       <= RST_CTRL;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign reg_rdata     = s_r.rdata;
	assign speed_demand  = s_r.dem;
	assign flags         = '{speed_near_zero_flag: speed_nz, setpoint_near_zero_flag: setpt_nz,
				motor_stopped_flag: stopped};
	assign zero_relay    = speed_nz;
	assign not_stopped   = !stopped;
	assign contactor_on  = (s_r.st == ST_RUN) || (s_r.st == ST_NSTOP)
				|| (s_r.st == ST_HOLD) || (s_r.st == ST_PSTOP);
	assign drive_enable  = (s_r.st == ST_RUN) || (s_r.st == ST_NSTOP) || (s_r.st == ST_PSTOP)
				|| ((s_r.st == ST_HOLD) && !early_off);
	assign loops_enable  = drive_enable && en_ok && !quench_now;
	assign run_led       = contactor_on;
	assign current_limit = (s_r.st == ST_PSTOP) ? s_r.cfg.fast_ilim : ILIM_NONE;

	AST_NOT_STOPPED: assert property (@(posedge sys_clk) disable iff (sys_rst)
		not_stopped != flags.motor_stopped_flag)
		else $error("not-stopped is not the inverse of stopped");
	AST_QUENCH: assert property (@(posedge sys_clk) disable iff (sys_rst)
		quench_now |-> contactor_on && run_led && !loops_enable)
		else $error("standstill quench wrong");
	AST_HOLD_CANCEL: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(s_r.st == ST_HOLD) && halt_ok && !en_ok |=> !contactor_on)
		else $error("contactor delay not cancelled by enable low");
	AST_HOLD_END: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(s_r.st == ST_HOLD) && halt_ok && (s_r.tmr < s_r.cfg.hold_dly) && en_ok && coast_ok |=> contactor_on)
		else $error("contactor dropped before hold delay");
	AST_EARLY_OFF: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(s_r.st == ST_HOLD) |-> (drive_enable == !early_off))
		else $error("drive enable wrong during contactor delay");
	AST_FAST_ZERO: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(s_r.st == ST_PSTOP) && at_stop_zero |=> !contactor_on && !drive_enable)
		else $error("fast stop did not end at stop zero level");
	AST_FAST_LIM: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(s_r.st == ST_PSTOP) && (s_r.tmr >= s_r.cfg.fast_lim) |=> !contactor_on)
		else $error("fast stop limit not enforced");
	AST_NSTOP_LIM: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(s_r.st == ST_NSTOP) && halt_ok && !run_ok && !at_stop_zero
		&& (s_r.tmr >= s_r.cfg.nstop_lim) |=> !contactor_on && !drive_enable)
		else $error("normal stop limit not enforced");
	AST_PRIORITY: assert property (@(posedge sys_clk) disable iff (sys_rst)
		((s_r.st == ST_NSTOP) || (s_r.st == ST_HOLD)) && !halt_ok && coast_ok |=> (s_r.st == ST_PSTOP))
		else $error("fast stop did not take over");
	AST_ILIM: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(s_r.st == ST_PSTOP) |-> current_limit == s_r.cfg.fast_ilim)
		else $error("fast stop current limit not applied");
	AST_RAMP: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(s_r.st == ST_NSTOP) && s_r.cfg.ctrl[CTRL_REGEN] && step && (s_r.dem > 16'sh0000)
		&& halt_ok && !run_ok && !at_stop_zero && coast_ok |=> speed_demand == $past(speed_demand) - 16'sh0001)
		else $error("normal stop ramp step missing");

endmodule : szs_seq

`default_nettype wire

// File: dv/szs_motor_model.sv
// Behavioural motor, power stage and main contactor facing the sequencer.
// Assumes demand and enables come from the sequencer on sys_clk.
`default_nettype none

module szs_motor_model (
	input  wire logic               sys_clk,
	input  wire logic               sys_rst,
	input  wire logic signed [15:0] speed_demand,
	input  wire logic               contactor_on,
	input  wire logic               drive_enable,
	input  wire logic               loops_enable,
	input  wire logic               stall,
	input  wire logic               load,
	input  wire logic signed [15:0] load_val,
	output var  logic signed [15:0] speed_fb
);
	timeunit 1ns;
	timeprecision 1ns;

	logic signed [16:0] err;
	logic        [5:0]  coast_cnt;

	assign err = {speed_demand[15], speed_demand} - {speed_fb[15], speed_fb};

	// Powered shaft slews to demand, unpowered coasts slowly, stall jams it
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			speed_fb  <= 16'sh0000;
			coast_cnt <= 6'h00;
		end else if (load) begin
			speed_fb  <= load_val;
			coast_cnt <= 6'h00;
		end else if (!stall) begin
			coast_cnt <= coast_cnt + 6'h01;
			if (contactor_on && drive_enable && loops_enable) begin
				if (err > 17'sh00004)
					speed_fb <= speed_fb + 16'sh0004;
				else if (err < -17'sh00004)
					speed_fb <= speed_fb - 16'sh0004;
				else
					speed_fb <= speed_demand;
			end else if (coast_cnt == 6'h3F && speed_fb != 16'sh0000) begin
				speed_fb <= (speed_fb > 16'sh0000) ? speed_fb - 16'sh0001 : speed_fb + 16'sh0001;
			end
		end
	end

endmodule : szs_motor_model

`default_nettype wire

// File: dv/tb.sv
// Self-checking bench of the standstill and stop sequencer.
// Assumes the motor model closes the loop; timer tick shortened to 10000 cycles.
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import szs_pkg::*;

	localparam int TCYC = 10000;
	logic               sys_clk, sys_rst, reg_wr, reg_rd, stall, load;
	logic               run_input, fast_halt_input, enable_input, coast_input;
	logic [3:0]         reg_addr;
	logic [15:0]        reg_wdata, reg_rdata, current_limit, rd_val;
	logic signed [15:0] speed_fb, speed_setpoint, speed_demand, load_val;
	szs_flags_t         flags;
	logic               zero_relay, not_stopped, loops_enable, contactor_on, drive_enable, run_led;
	int                 failures = 0, cmp_count = 0, cycles = 0, n, m;
	logic [15:0]        rst_tab [10] = '{RST_ZERO_LVL, RST_NSTOP_TIME, RST_NSTOP_LIM, RST_HOLD_DLY, RST_QUENCH,
		RST_FAST_TIME, RST_FAST_LIM, RST_FAST_ILIM, RST_STOP_ZERO, RST_CTRL};
	int                 fb_tab [11] = '{150, 230, 260, 230, 150, -230, -260, 200, 199, 249, 250};
	int                 sp_tab [11] = '{150, 230, 260, 230, 150, -230, -260, 200, 199, 900, 100};
	logic [1:0]         nz_tab [11] = '{2'h3, 2'h3, 2'h0, 2'h0, 2'h3, 2'h3, 2'h0, 2'h0, 2'h3, 2'h2, 2'h1};

	szs_seq #(.TICK_CYC(TCYC)) szs_seq_i (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .run_input(run_input),
		.fast_halt_input(fast_halt_input), .enable_input(enable_input), .coast_input(coast_input),
		.speed_fb(speed_fb), .speed_setpoint(speed_setpoint), .flags(flags), .zero_relay(zero_relay),
		.not_stopped(not_stopped), .loops_enable(loops_enable), .contactor_on(contactor_on),
		.drive_enable(drive_enable), .run_led(run_led), .speed_demand(speed_demand),
		.current_limit(current_limit)
	);

	szs_motor_model szs_motor_model_i (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .speed_demand(speed_demand), .contactor_on(contactor_on),
		.drive_enable(drive_enable), .loops_enable(loops_enable), .stall(stall), .load(load),
		.load_val(load_val), .speed_fb(speed_fb)
	);

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			failures = failures + 1;
			complete_run;
		end
	end

	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task chk_rng(input int got, input int lo, input int hi);
		cmp_count++;
		if (got < lo || got > hi) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, lo);
		end
	endtask : chk_rng

	task cyc(input int k);
		repeat (k) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : cyc

	task pins(input logic r, input logic h, input logic e, input logic c);
		@(posedge sys_clk);
		run_input       <= r;
		fast_halt_input <= h;
		enable_input    <= e;
		coast_input     <= c;
	endtask : pins

	task go;
		pins(1'b1, 1'b1, 1'b1, 1'b1);
		cyc(400);
	endtask : go

	task set_stall(input logic s);
		@(posedge sys_clk);
		stall <= s;
	endtask : set_stall

	task ld(input logic signed [15:0] fb, input logic signed [15:0] sp);
		@(posedge sys_clk);
		load           <= 1'b1;
		load_val       <= fb;
		speed_setpoint <= sp;
		@(posedge sys_clk);
		load           <= 1'b0;
		cyc(3);
	endtask : ld

	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
	endtask : wr

	task rd(input logic [3:0] a);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd   <= 1'b0;
		@(negedge sys_clk);
		rd_val = reg_rdata;
	endtask : rd

	task chk_reg(input logic [3:0] a, input logic [15:0] e);
		rd(a);
		chk(rd_val, e);
	endtask : chk_reg

	task st(input logic [5:0] e);
		rd(OFS_STATUS);
		chk({10'h000, rd_val[13:8]}, {10'h000, e});
	endtask : st

	function automatic logic hit(input int w);
		case (w)
			0: return contactor_on === 1'b0;
			1: return speed_demand === 16'sh0000;
			2: return drive_enable === 1'b0;
			default: return (speed_fb < 16'sh00C8) && (speed_fb > -16'sh00C8);
		endcase
	endfunction : hit

	// Cycles until the chosen event, capped at lim
	task meas(input int w, input int lim);
		n = 0;
		while (!hit(w) && n < lim) begin
			@(negedge sys_clk);
			n++;
		end
	endtask : meas

	initial begin
		sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 16'h0000;
		run_input = 1'b0; fast_halt_input = 1'b1; enable_input = 1'b1; coast_input = 1'b1;
		speed_setpoint = 16'sh0000; stall = 1'b0; load = 1'b0; load_val = 16'sh0000;
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 10; i++) chk_reg(4'(i), rst_tab[i]);
		wr(OFS_DEMAND, 16'h1234);
		chk_reg(OFS_DEMAND, 16'h0000);
		chk_reg(4'hC, 16'h0000);
		wr(OFS_CTRL, 16'hFFFF);
		chk_reg(OFS_CTRL, 16'h0003);
		wr(OFS_NSTOP_TIME, 16'h0003);
		wr(OFS_HOLD_DLY, 16'h0001);
		wr(OFS_FAST_ILIM, 16'h1388);
		chk_reg(OFS_FAST_ILIM, 16'h1388);
		for (int i = 0; i < 11; i++) begin
			ld(16'(fb_tab[i]), 16'(sp_tab[i]));
			chk({13'h0000, flags}, {13'h0000, nz_tab[i], &nz_tab[i]});
			chk({14'h0000, zero_relay, not_stopped}, {14'h0000, nz_tab[i][1], ~&nz_tab[i]});
		end
		// Standstill quench in run, then setpoint lifts it
		ld(16'sh0000, 16'sh0000);
		go;
		st(ST_RUN);
		chk({13'h0000, loops_enable, contactor_on, run_led}, 16'h0003);
		chk({15'h0000, not_stopped}, 16'h0000);
		ld(16'sh0000, 16'sh03E8);
		chk({15'h0000, loops_enable}, 16'h0001);
		wr(OFS_CTRL, 16'h0002);
		cyc(400);
		// Regenerative normal stop with jammed shaft, then release
		set_stall(1'b1);
		pins(1'b0, 1'b1, 1'b1, 1'b1);
		meas(1, 6000);
		chk_rng(n, 2990, 3020);
		set_stall(1'b0);
		meas(3, 1000);
		meas(0, 5000);
		chk_rng(n, 5000, 5000);
		chk({14'h0000, contactor_on, drive_enable}, 16'h0003);
		m = n;
		meas(0, 20000);
		chk_rng(m + n, 9995, 10040);
		chk({15'h0000, drive_enable}, 16'h0000);
		cyc(6);
		// Early disable in hold, then enable low cancels the delay
		wr(OFS_QUENCH, 16'h0064);
		go;
		pins(1'b0, 1'b1, 1'b1, 1'b1);
		meas(2, 6000);
		chk({14'h0000, contactor_on, drive_enable}, 16'h0002);
		st(ST_HOLD);
		pins(1'b0, 1'b1, 1'b0, 1'b1);
		meas(0, 20);
		chk_rng(n, 1, 6);
		pins(1'b0, 1'b1, 1'b1, 1'b1);
		wr(OFS_QUENCH, 16'h0000);
		cyc(6);
		// Normal stop limit timer
		wr(OFS_NSTOP_LIM, 16'h0001);
		go;
		set_stall(1'b1);
		pins(1'b0, 1'b1, 1'b1, 1'b1);
		meas(0, 20000);
		chk_rng(n, 9995, 10030);
		chk({15'h0000, drive_enable}, 16'h0000);
		set_stall(1'b0);
		wr(OFS_NSTOP_LIM, RST_NSTOP_LIM);
		cyc(6);
		// Both stops at once: fast stop wins
		go;
		set_stall(1'b1);
		pins(1'b0, 1'b0, 1'b1, 1'b1);
		cyc(4);
		chk(current_limit, 16'h1388);
		st(ST_PSTOP);
		meas(1, 4000);
		chk_rng(n, 970, 1010);
		set_stall(1'b0);
		meas(0, 2000);
		chk_rng(n, 1, 1000);
		cyc(2);
		chk(current_limit, ILIM_NONE);
		st(ST_LOCK);
		pins(1'b0, 1'b1, 1'b1, 1'b1);
		cyc(6);
		// Fast stop limit timer, then refused run requests
		wr(OFS_FAST_LIM, 16'h0001);
		go;
		set_stall(1'b1);
		pins(1'b1, 1'b0, 1'b1, 1'b1);
		meas(0, 20000);
		chk_rng(n, 9995, 10030);
		set_stall(1'b0);
		pins(1'b1, 1'b1, 1'b1, 1'b1);
		cyc(10);
		chk({15'h0000, contactor_on}, 16'h0000);
		st(ST_LOCK);
		pins(1'b0, 1'b1, 1'b1, 1'b1);
		cyc(6);
		st(ST_OFF);
		pins(1'b1, 1'b1, 1'b1, 1'b0);
		cyc(6);
		st(ST_LOCK);
		chk({15'h0000, contactor_on}, 16'h0000);
		pins(1'b0, 1'b1, 1'b1, 1'b1);
		cyc(6);
		// Non-regenerative stop drops demand at once
		wr(OFS_CTRL, 16'h0000);
		go;
		pins(1'b0, 1'b1, 1'b1, 1'b1);
		cyc(5);
		chk(speed_demand, 16'h0000);
		st(ST_NSTOP);
		complete_run;
	end

endmodule : tb

`default_nettype wire
